// File: rtl/rvob_map.vh
// constants for the variant option bits block: data width, bit positions, reset value, variant codes, mask defaults
`ifndef RVOB_MAP_VH
`define RVOB_MAP_VH

// data width of every register in this block
`define RVOB_DW 8
// reset cause status: forced monitor entry position
`define RVOB_RCS_FME_BIT 2
// mask option register two: pump regulator disable position
`define RVOB_MASK_OPTION_REG_TWO_PRD_BIT 2
// reset value of the writable configuration registers
`define RVOB_CFG_RST 8'h00
// variant codes
`define RVOB_VAR_NVM 1'b0
`define RVOB_VAR_ROM 1'b1
// default mask contents (arbitrary neutral pattern, set at manufacture)
`define RVOB_MASK_ONE_DEF 8'h00
`define RVOB_MASK_TWO_DEF 8'h00

`endif

// File: rtl/rvob_once_reg.v
// write-once configuration register with fixed-contents option
`timescale 1ns/100ps
module rvob_once_reg #(
  parameter WIDTH = 8,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}},
  parameter [WIDTH-1:0] FIXED_VAL = {WIDTH{1'b0}},
  parameter [WIDTH-1:0] ZERO_MASK = {WIDTH{1'b0}}
) (
  clk_sys,
  rst_b,
  mask_rom,
  wr_en,
  wr_data,
  rd_data,
  locked
);
  input wire clk_sys; // system clock
  input wire rst_b; // async reset, active low
  input wire mask_rom; // high in the mask-programmed variant
  input wire wr_en; // write strobe
  input wire [WIDTH-1:0] wr_data; // write data
  output reg [WIDTH-1:0] rd_data; // read value, registered
  output reg locked; // set after the single accepted write

  // ==========================================================
  // storage
  reg [WIDTH-1:0] cfg_q; // writable contents
  reg [WIDTH-1:0] cfg_d; // next contents
  reg lock_d; // next lock state

  // next state: one write accepted per reset in the writable variant
  always @* begin
    cfg_d = cfg_q;
    lock_d = locked;
    if (wr_en && !locked && !mask_rom) begin
      cfg_d = wr_data;
      lock_d = 1'b1;
    end
  end

  // registers; mask variant always reads the fixed pattern
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= RST_VAL;
      locked <= 1'b0;
      rd_data <= {WIDTH{1'b0}};
    end else begin
      cfg_q <= cfg_d;
      locked <= lock_d;
      if (mask_rom) begin
        rd_data <= FIXED_VAL & ~ZERO_MASK;
      end else begin
        rd_data <= cfg_d & ~ZERO_MASK;
      end
    end
  end
endmodule

// File: rtl/rvob_top.v
// option bits and status bits that differ between the mask-programmed and reprogrammable variants
`timescale 1ns/100ps
`include "rvob_map.vh"
module rvob_top #(
  // data width of every register in the block
  parameter DW = `RVOB_DW,
  // mask contents fixed at manufacture
  parameter [DW-1:0] MASK_ONE = `RVOB_MASK_ONE_DEF,
  parameter [DW-1:0] MASK_TWO = `RVOB_MASK_TWO_DEF,
  // contents of the writable registers after reset
  parameter [DW-1:0] CFG_RST = `RVOB_CFG_RST
) (
  input wire clk_sys,
  input wire rst_b,
  // variant strap and the two option register writes
  input wire variant_rom,
  input wire cfg_one_wr,
  input wire cfg_two_wr,
  input wire [DW-1:0] cfg_wr_data,
  // raw reset causes and monitor requests
  input wire [DW-1:0] reset_cause_raw,
  input wire vector_erased,
  input wire monitor_pin_entry,
  input wire security_pass,
  input wire mon_prog_req,
  input wire mon_exec_req,
  input wire mon_exec_in_ram,
  // memory control register write port
  input wire nvm_reg_wr,
  input wire [DW-1:0] nvm_reg_wr_data,
  // option register mirrors and their lock flags
  output reg [DW-1:0] mask_option_reg_one,
  output reg [DW-1:0] mask_option_reg_two,
  output reg cfg_one_locked,
  output reg cfg_two_locked,
  // status, monitor and memory control outputs
  output reg [DW-1:0] reset_cause_status,
  output reg pump_regulator_disable,
  output reg forced_monitor_entry_reset,
  output reg monitor_firmware_active,
  output reg mon_prog_strobe,
  output reg mon_exec_grant,
  output reg user_mem_read_ok,
  output reg [DW-1:0] nvm_program_erase_control,
  output reg [DW-1:0] nvm_block_protect,
  output reg [DW-1:0] nvm_test_control
);

  // ==========================================================
  // variant strap, caught on the first clock after reset release
  // the pin is read once so that a later glitch cannot flip the variant
  // under a running program
  reg rom_q; // captured variant
  reg strap_done_q; // strap capture finished

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rom_q <= 1'b0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      rom_q <= variant_rom;
      strap_done_q <= 1'b1;
    end
  end

  // live variant: the pin itself on the capture edge, the latched strap afterwards
  // hazard avoided: a mask part must never act as a writable part for one cycle
  wire rom_now; // variant used by every decision below
  assign rom_now = strap_done_q ? rom_q : variant_rom;

  // ==========================================================
  // option registers
  // clears one bit position of a register image; used for both read-as-zero bits
  function [DW-1:0] rvob_clear_bit;
    input [DW-1:0] value; // register image
    input integer pos; // bit to clear
    begin
      rvob_clear_bit = value & ~({{(DW-1){1'b0}}, 1'b1} << pos);
    end
  endfunction

  wire [DW-1:0] opt_one_rd; // first option register read value
  wire [DW-1:0] opt_two_rd; // second option register read value
  wire opt_one_lock; // first register lock
  wire opt_two_lock; // second register lock
  wire [DW-1:0] cfg_two_raw; // second register with pump bit retained

  // first option register
  // writes pass only once the strap is known, so none slips into a mask part
  rvob_once_reg #(.WIDTH(DW), .RST_VAL(CFG_RST), .FIXED_VAL(MASK_ONE), .ZERO_MASK({DW{1'b0}})) u_opt_one (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .mask_rom(rom_now),
    .wr_en(cfg_one_wr & strap_done_q),
    .wr_data(cfg_wr_data),
    .rd_data(opt_one_rd),
    .locked(opt_one_lock)
  );

  // second option register; pump bit forced to zero in the mask variant only
  rvob_once_reg #(.WIDTH(DW), .RST_VAL(CFG_RST), .FIXED_VAL(MASK_TWO), .ZERO_MASK({DW{1'b0}})) u_opt_two (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .mask_rom(rom_now),
    .wr_en(cfg_two_wr & strap_done_q),
    .wr_data(cfg_wr_data),
    .rd_data(cfg_two_raw),
    .locked(opt_two_lock)
  );
  assign opt_two_rd = rom_now ? rvob_clear_bit(cfg_two_raw, `RVOB_MASK_OPTION_REG_TWO_PRD_BIT) : cfg_two_raw;

  // ==========================================================
  // option register mirrors and lock flags
  // every top output is a flip-flop, so the option values take one more stage here
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      // all mirrors clear while reset is held
      mask_option_reg_one <= {DW{1'b0}};
      mask_option_reg_two <= {DW{1'b0}};
      cfg_one_locked <= 1'b0;
      cfg_two_locked <= 1'b0;
    end else begin
      // mask variant shows the fixed pattern with the pump bit cleared in the second, writable variant the stored word
      mask_option_reg_one <= opt_one_rd;
      mask_option_reg_two <= opt_two_rd;
      // lock flags tell software that the single write has been used
      cfg_one_locked <= opt_one_lock;
      cfg_two_locked <= opt_two_lock;
    end
  end

  // ==========================================================
  // reset cause status and pump regulator disable
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      // status clear while reset is held
      reset_cause_status <= {DW{1'b0}};
      pump_regulator_disable <= 1'b0;
    end else if (rom_now) begin
      // forced entry cause does not exist in the mask variant, so it reads zero
      reset_cause_status <= rvob_clear_bit(reset_cause_raw, `RVOB_RCS_FME_BIT);
      // no charge pump to switch off: the bit is inert
      pump_regulator_disable <= 1'b0;
    end else begin
      // writable variant passes every cause bit through
      reset_cause_status <= reset_cause_raw;
      // pump control follows the stored option bit
      pump_regulator_disable <= opt_two_rd[`RVOB_MASK_OPTION_REG_TWO_PRD_BIT];
    end
  end

  // ==========================================================
  // monitor entry and monitor command gating
  // the decision uses the live variant so the capture edge is already safe
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      // monitor idle while reset is held
      forced_monitor_entry_reset <= 1'b0;
      monitor_firmware_active <= 1'b0;
      mon_prog_strobe <= 1'b0;
      mon_exec_grant <= 1'b0;
      user_mem_read_ok <= 1'b0;
    end else begin
      if (rom_now) begin
        // erased vector ignored: entry only through the normal pin path
        forced_monitor_entry_reset <= 1'b0;
        monitor_firmware_active <= monitor_pin_entry;
        // programming commands have nothing to program
        mon_prog_strobe <= 1'b0;
      end else begin
        // an unprogrammed vector forces the monitor in the writable variant
        forced_monitor_entry_reset <= vector_erased;
        monitor_firmware_active <= monitor_pin_entry | vector_erased;
        // programming allowed only once the security check has passed
        mon_prog_strobe <= mon_prog_req & security_pass;
      end
      // ram code always runs; user memory code needs the security check
      mon_exec_grant <= mon_exec_req & (mon_exec_in_ram | security_pass);
      // user memory readable by the monitor only after the security check
      user_mem_read_ok <= security_pass;
    end
  end

  // ==========================================================
  // memory control registers of the writable variant
  // in the mask variant these read as zero and swallow every write
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      // control registers clear while reset is held
      nvm_program_erase_control <= {DW{1'b0}};
      nvm_block_protect <= {DW{1'b0}};
      nvm_test_control <= {DW{1'b0}};
    end else if (rom_now) begin
      // registers absent: read as zero, writes dropped
      nvm_program_erase_control <= {DW{1'b0}};
      nvm_block_protect <= {DW{1'b0}};
      nvm_test_control <= {DW{1'b0}};
    end else begin
      // program and erase control takes software writes
      if (nvm_reg_wr) begin
        nvm_program_erase_control <= nvm_reg_wr_data;
      end
      // protection and test stay at their idle value
      nvm_block_protect <= {DW{1'b0}};
      nvm_test_control <= {DW{1'b0}};
    end
  end
endmodule

// File: dv/rvob_top_properties.sv
// checker for the variant option bits top level
`timescale 1ns/100ps
module rvob_chk_props #(
  parameter [7:0] MASK_ONE = 8'h00,
  parameter [7:0] MASK_TWO = 8'h00
) (
  input wire clk_sys,
  input wire rst_b,
  input wire variant_rom,
  input wire cfg_one_wr,
  input wire [7:0] cfg_wr_data,
  input wire mon_exec_req,
  input wire mon_exec_in_ram,
  input wire security_pass,
  input wire [7:0] mask_option_reg_one,
  input wire [7:0] mask_option_reg_two,
  input wire cfg_one_locked,
  input wire [7:0] reset_cause_status,
  input wire pump_regulator_disable,
  input wire forced_monitor_entry_reset,
  input wire mon_prog_strobe,
  input wire mon_exec_grant,
  input wire user_mem_read_ok,
  input wire [7:0] nvm_program_erase_control,
  input wire [7:0] nvm_block_protect,
  input wire [7:0] nvm_test_control
);
  // =====
  // properties
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // first write of a reset period in the writable variant
  sequence s_first; !variant_rom && !cfg_one_locked && cfg_one_wr && !$past(cfg_one_wr); endsequence
  property p_fme; variant_rom |-> !reset_cause_status[2]; endproperty
  property p_nofe; variant_rom |-> !forced_monitor_entry_reset; endproperty
  property p_pump; variant_rom |-> !pump_regulator_disable && !mask_option_reg_two[2]; endproperty
  property p_prog; variant_rom |-> !mon_prog_strobe; endproperty
  property p_nvm; variant_rom |-> (nvm_program_erase_control | nvm_block_protect | nvm_test_control) == 8'h00; endproperty
  property p_mask; variant_rom && cfg_one_wr |-> ##2 mask_option_reg_one == MASK_ONE; endproperty
  property p_once; s_first |-> ##2 (mask_option_reg_one == $past(cfg_wr_data, 2)) && cfg_one_locked; endproperty
  property p_hold; cfg_one_locked |=> $stable(mask_option_reg_one); endproperty
  property p_exec; !mon_exec_req |=> !mon_exec_grant; endproperty
  property p_sec; !security_pass |=> !user_mem_read_ok; endproperty
  property p_ram; mon_exec_req && mon_exec_in_ram |=> mon_exec_grant; endproperty
  a_fme: assert property (p_fme) else $error("status bit two set");
  a_nofe: assert property (p_nofe) else $error("forced entry seen");
  a_pump: assert property (p_pump) else $error("pump bit set");
  a_prog: assert property (p_prog) else $error("program strobe seen");
  a_nvm: assert property (p_nvm) else $error("nvm register nonzero");
  a_mask: assert property (p_mask) else $error("mask reg changed");
  a_once: assert property (p_once) else $error("first write lost");
  a_hold: assert property (p_hold) else $error("locked reg moved");
  a_exec: assert property (p_exec) else $error("grant without request");
  a_sec: assert property (p_sec) else $error("read allowed unsecured");
  a_ram: assert property (p_ram) else $error("ram execution refused");
endmodule
bind rvob_top rvob_chk_props #(.MASK_ONE(MASK_ONE), .MASK_TWO(MASK_TWO)) chk_i (.*);

// File: dv/rvob_top_tb.sv
// self-checking bench for the variant option bits block
`timescale 1ns/100ps
module rvob_top_tb;
  reg clk_sys = 1'b0;
  reg rst_b = 1'b0;
  reg variant_rom = 1'b1, cfg_one_wr = 1'b0, cfg_two_wr = 1'b0, vector_erased = 1'b1, monitor_pin_entry = 1'b1;
  reg security_pass = 1'b0, mon_prog_req = 1'b1, mon_exec_req = 1'b0, mon_exec_in_ram = 1'b1, nvm_reg_wr = 1'b1;
  reg [7:0] cfg_wr_data = 8'h00, reset_cause_raw = 8'hFF, nvm_reg_wr_data = 8'hFF;
  wire [7:0] mask_option_reg_one, mask_option_reg_two, reset_cause_status;
  wire [7:0] nvm_program_erase_control, nvm_block_protect, nvm_test_control;
  wire cfg_one_locked, cfg_two_locked, pump_regulator_disable, forced_monitor_entry_reset;
  wire monitor_firmware_active, mon_prog_strobe, mon_exec_grant, user_mem_read_ok;
  integer err_count = 0, compares = 0, cyc = 0, i;
  reg [7:0] d [0:1];
  rvob_top #(.MASK_ONE(8'hC3), .MASK_TWO(8'h3C)) dut (.*);
  initial forever #20 clk_sys = ~clk_sys;
  // cut a hang short
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      err_count = err_count + 1;
      print_verdict;
    end
  end
  task chk(input [8*8:1] nm, input [7:0] seen, input [7:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("CHECK FAILED %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // reset held 12 cycles, variant chosen meanwhile
  task run_reset(input v);
    begin
      @(posedge clk_sys);
      rst_b <= 1'b0;
      variant_rom <= v;
      repeat (12) @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk_sys);
    end
  endtask
  // back-to-back writes: the second one must be refused
  task wr_pair(input [7:0] a);
    begin
      cfg_one_wr <= 1'b1;
      cfg_two_wr <= 1'b1;
      cfg_wr_data <= a;
      @(posedge clk_sys);
      cfg_wr_data <= ~a;
      @(posedge clk_sys);
      cfg_one_wr <= 1'b0;
      cfg_two_wr <= 1'b0;
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
    end
  endtask
  // monitor inputs set on one edge, outputs read settled two edges later
  task mon_set(input pin, input req, input ram, input sec, input vec);
    begin
      @(posedge clk_sys);
      monitor_pin_entry <= pin;
      mon_exec_req <= req;
      mon_exec_in_ram <= ram;
      security_pass <= sec;
      vector_erased <= vec;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
    end
  endtask
  task print_verdict;
    begin
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    d[0] = 8'hA5;
    d[1] = 8'h3C;
    run_reset(1'b1);
    wr_pair(8'hA5);
    chk("mask one", mask_option_reg_one, 8'hC3);
    chk("mask two", mask_option_reg_two, 8'h38);
    chk("status", reset_cause_status, 8'hFB);
    chk("flags", {forced_monitor_entry_reset, mon_prog_strobe, pump_regulator_disable, 5'h00}, 8'h00);
    chk("nvm", nvm_program_erase_control | nvm_block_protect | nvm_test_control, 8'h00);
    mon_set(1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
    chk("mon act", {7'h00, monitor_firmware_active}, 8'h00);
    chk("exec ram", {7'h00, mon_exec_grant}, 8'h01);
    mon_set(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    chk("mon act", {7'h00, monitor_firmware_active}, 8'h01);
    chk("exec rom", {7'h00, mon_exec_grant}, 8'h00);
    chk("read ok", {7'h00, user_mem_read_ok}, 8'h00);
    mon_set(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    chk("exec rom", {7'h00, mon_exec_grant}, 8'h01);
    chk("read ok", {7'h00, user_mem_read_ok}, 8'h01);
    chk("prog", {7'h00, mon_prog_strobe}, 8'h00);
    mon_set(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    chk("fme", {7'h00, forced_monitor_entry_reset}, 8'h00);
    for (i = 0; i < 2; i = i + 1) begin
      run_reset(1'b0);
      wr_pair(d[i]);
      chk("opt one", mask_option_reg_one, d[i]);
      chk("opt two", mask_option_reg_two, d[i]);
      chk("locks", {6'h00, cfg_one_locked, cfg_two_locked}, 8'h03);
      chk("pump", {7'h00, pump_regulator_disable}, {7'h00, d[i][2]});
      chk("status", reset_cause_status, 8'hFF);
      chk("fme", {7'h00, forced_monitor_entry_reset}, 8'h01);
      chk("pec", nvm_program_erase_control, 8'hFF);
      chk("bp tc", nvm_block_protect | nvm_test_control, 8'h00);
    end
    chk("read ok", {7'h00, user_mem_read_ok}, 8'h00);
    print_verdict;
  end
endmodule
